// ### core/brownout_defines.svh
// Contract
// RULE1 - Warning interrupt suppressed while processor debug-halted
// RULE2 - Flag set regardless of interrupt enable
// RULE3 - Request while enabled and flagged, until cleared
// RULE4 - Awake mode loaded from fuses, read-only
// RULE5 - Sleep uses sleep mode, wake uses awake mode
// RULE6 - Software unlocks, then writes within four instructions
// RULE7 - Sleep field unchanged without valid unlock
// RULE8 - Sample rate bit: 0 1kHz, 1 125Hz
// RULE9 - Awake decode; code 3 stalls wake until running
// RULE10 - Sleep decode; code 3 reserved; fuse reset
// RULE11 - Read-only three-bit threshold level from fuses
// RULE12 - Margin codes 0,1,2 give 5/15/25 percent
// RULE13 - Trigger: fall, rise, either; others reserved
// RULE14 - Writing one enables warning interrupt
// RULE15 - Flag set on matching trigger, detector enabled
// RULE16 - Status one when supply below warning threshold
// RULE17 - Monitor follows detector mode, sampled too
// RULE18 - System reset when supply below threshold
// RULE19 - Flag cleared by writing one
// RULE20 - Comparator synchronised before edge detection
`ifndef BROWNOUT_DEFINES_SVH
`define BROWNOUT_DEFINES_SVH
`define ADDR_MODE_CTRL 4'h0
`define ADDR_LEVEL_CFG 4'h1
`define ADDR_MARGIN_CTRL 4'h8
`define ADDR_IRQ_CTRL 4'h9
`define ADDR_IRQ_FLAGS 4'hA
`define ADDR_STATE 4'hB
`define BIT_SAMPLE_RATE 4
`define FLD_AWAKE_HI 3
`define FLD_AWAKE_LO 2
`define FLD_SLEEP_HI 1
`define FLD_SLEEP_LO 0
`define FLD_TRIG_HI 2
`define FLD_TRIG_LO 1
`define BIT_IRQ_EN 0
`define BIT_FLAG 0
`define UNLOCK_WINDOW 3'h4
`define SAMPLE_FAST_HZ 1000
`define SAMPLE_SLOW_HZ 125
`define CLK_HZ 50000000
`define SAMPLE_FAST_CYC (`CLK_HZ / `SAMPLE_FAST_HZ)
`define SAMPLE_SLOW_CYC (`CLK_HZ / `SAMPLE_SLOW_HZ)
`define FLD_MARGIN_HI 1
`define FLD_MARGIN_LO 0
`define WAKE_STALL_CYC 16
`define RESET_BYTE 8'h00
`endif

// ### core/brownout_pkg.sv
package brownout_pkg;
    typedef enum logic [1:0] {
        MODE_DIS = 2'h0,
        MODE_CONT = 2'h1,
        MODE_SAMP = 2'h2,
        MODE_CONT_HOLD = 2'h3
    } det_mode_e;
    typedef enum logic [1:0] {
        TRIG_BELOW = 2'h0,
        TRIG_ABOVE = 2'h1,
        TRIG_CROSS = 2'h2,
        TRIG_RSVD = 2'h3
    } trig_e;
    typedef logic [7:0] byte_t;
endpackage : brownout_pkg

// ### core/brownout_monitor_control.sv
`include "brownout_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module brownout_monitor_control #(
    parameter int unsigned FAST_CYC = `SAMPLE_FAST_CYC,
    parameter int unsigned SLOW_CYC = `SAMPLE_SLOW_CYC,
    parameter int unsigned WAKE_HOLD_CYC = `WAKE_STALL_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic [1:0] fuse_sleep_mode,
    input wire logic [1:0] fuse_awake_mode,
    input wire logic fuse_sample_rate,
    input wire logic [2:0] fuse_threshold,
    input wire logic unlock_key_written,
    input wire logic instr_retired,
    input wire logic sleep_deep,
    input wire logic debug_halted,
    input wire logic brownout_cmp,
    input wire logic warn_cmp,
    output logic detector_on,
    output logic detector_sample,
    output logic [2:0] brownout_threshold_sel,
    output logic [1:0] early_warn_margin_sel,
    output logic early_warn_irq,
    output logic wake_stall,
    output logic system_reset_req
);
    // Configuration captured from fuses
    logic fuse_loaded_q;
    logic [1:0] awake_mode_q;
    logic [1:0] awake_mode_d;
    logic [1:0] sleep_mode_q;
    logic [1:0] sleep_mode_d;
    logic sample_rate_sel_q;
    logic sample_rate_sel_d;
    logic [2:0] threshold_q;
    logic [2:0] threshold_d;

    // Software-writable warning configuration
    logic [1:0] margin_q;
    logic [1:0] margin_d;
    logic [1:0] trigger_q;
    logic [1:0] trigger_d;
    logic irq_en_q;
    logic irq_en_d;

    // Warning flag
    logic flag_q;
    logic flag_d;

    // Unlock window counter
    logic [2:0] unlock_cnt_q;
    logic [2:0] unlock_cnt_d;

    // Sleep tracking, sample timing and wake stall
    logic sleep_q;
    logic [31:0] samp_cnt_q;
    logic [31:0] samp_cnt_d;
    logic samp_tick_q;
    logic [31:0] wake_cnt_q;
    logic [31:0] wake_cnt_d;
    logic wake_stall_d;

    // Comparator synchronisers and edge history
    logic warn_s1_q;
    logic warn_s2_q;
    logic warn_prev_q;
    logic warn_prev_d;
    logic bo_s1_q;
    logic bo_s2_q;

    // Register address match
    function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] target);
        reg_hit = a == target;
    endfunction : reg_hit

    // Supply transition against the selected trigger type
    function automatic logic trig_match(input logic [1:0] sel, input logic below_edge, input logic above_edge);
        case (sel)
            brownout_pkg::TRIG_BELOW: trig_match = below_edge;
            brownout_pkg::TRIG_ABOVE: trig_match = above_edge;
            brownout_pkg::TRIG_CROSS: trig_match = below_edge || above_edge;
            default: trig_match = 1'b0;
        endcase
    endfunction : trig_match

    // Detector activity for a mode code in the current power state
    function automatic logic mode_runs(input logic [1:0] mode, input logic asleep);
        case (mode)
            brownout_pkg::MODE_CONT: mode_runs = 1'b1;
            brownout_pkg::MODE_SAMP: mode_runs = 1'b1;
            brownout_pkg::MODE_CONT_HOLD: mode_runs = !asleep;
            default: mode_runs = 1'b0;
        endcase
    endfunction : mode_runs

    // Address decode and write strobes
    wire wr_mode = wr_en && reg_hit(addr, `ADDR_MODE_CTRL);
    wire wr_margin = wr_en && reg_hit(addr, `ADDR_MARGIN_CTRL);
    wire wr_irq = wr_en && reg_hit(addr, `ADDR_IRQ_CTRL);
    wire wr_flags = wr_en && reg_hit(addr, `ADDR_IRQ_FLAGS);

    // Unlock window open while the counter is nonzero
    wire unlocked = unlock_cnt_q != 3'h0;
    wire sleep_wr_ok = wr_mode && unlocked; // RULE7

    // Mode in force: sleep field while deep asleep, awake field otherwise
    wire [1:0] mode_now = sleep_q ? sleep_mode_q : awake_mode_q; // RULE5
    // Reserved sleep code runs nothing
    wire det_en = fuse_loaded_q && mode_runs(mode_now, sleep_q); // RULE10
    wire det_samp = mode_now == brownout_pkg::MODE_SAMP; // RULE9

    // Sample period from the rate bit, slow when set
    wire [31:0] samp_period = sample_rate_sel_q ? SLOW_CYC : FAST_CYC; // RULE8
    wire samp_wrap = samp_cnt_q >= samp_period - 32'h1;

    // Monitor evaluates only when detector active, each tick if sampled
    wire mon_eval = det_en && (!det_samp || samp_tick_q); // RULE17
    wire fell_below = warn_s2_q && !warn_prev_q;
    wire rose_above = !warn_s2_q && warn_prev_q;
    wire trig_hit = trig_match(trigger_q, fell_below, rose_above); // RULE13
    wire flag_set = mon_eval && trig_hit; // RULE15
    wire flag_clr = wr_flags && wdata[`BIT_FLAG]; // RULE19

    // Leaving deep sleep with the hold-on-wake awake mode
    wire waking = sleep_q && !sleep_deep && awake_mode_q == brownout_pkg::MODE_CONT_HOLD;

    // Next values of the fuse-loaded fields
    assign awake_mode_d = fuse_loaded_q ? awake_mode_q : fuse_awake_mode; // RULE4
    assign sleep_mode_d = !fuse_loaded_q ? fuse_sleep_mode
        : sleep_wr_ok ? wdata[`FLD_SLEEP_HI:`FLD_SLEEP_LO] : sleep_mode_q; // RULE10 RULE7
    assign sample_rate_sel_d = !fuse_loaded_q ? fuse_sample_rate
        : wr_mode ? wdata[`BIT_SAMPLE_RATE] : sample_rate_sel_q; // RULE8
    assign threshold_d = fuse_loaded_q ? threshold_q : fuse_threshold; // RULE11

    // Next values of the software-writable fields
    assign margin_d = wr_margin ? wdata[`FLD_MARGIN_HI:`FLD_MARGIN_LO] : margin_q; // RULE12
    assign trigger_d = wr_irq ? wdata[`FLD_TRIG_HI:`FLD_TRIG_LO] : trigger_q; // RULE13
    assign irq_en_d = wr_irq ? wdata[`BIT_IRQ_EN] : irq_en_q; // RULE14

    // Set wins over a clear in the same cycle
    assign flag_d = flag_set || (flag_q && !flag_clr); // RULE2 RULE19

    // Key reloads the window; a guarded write or the fourth instruction uses it up
    assign unlock_cnt_d = unlock_key_written ? `UNLOCK_WINDOW
        : sleep_wr_ok ? 3'h0
        : (instr_retired && unlocked) ? unlock_cnt_q - 3'h1 : unlock_cnt_q; // RULE6

    // Free-running sample counter
    assign samp_cnt_d = samp_wrap ? 32'h0 : samp_cnt_q + 32'h1;

    // Edge history advances only on evaluation cycles
    assign warn_prev_d = mon_eval ? warn_s2_q : warn_prev_q; // RULE20

    // Wake stall counter and level
    assign wake_cnt_d = waking ? WAKE_HOLD_CYC
        : wake_cnt_q != 32'h0 ? wake_cnt_q - 32'h1 : wake_cnt_q;
    assign wake_stall_d = waking || wake_cnt_q > 32'h1; // RULE9

    // Read mux
    logic [7:0] rd_d;
    always_comb begin
        rd_d = `RESET_BYTE;
        case (addr)
            `ADDR_MODE_CTRL: rd_d = {3'h0, sample_rate_sel_q, awake_mode_q, sleep_mode_q};
            `ADDR_LEVEL_CFG: rd_d = {5'h0, threshold_q}; // RULE11
            `ADDR_MARGIN_CTRL: rd_d = {6'h0, margin_q};
            `ADDR_IRQ_CTRL: rd_d = {5'h0, trigger_q, irq_en_q};
            `ADDR_IRQ_FLAGS: rd_d = {7'h0, flag_q};
            `ADDR_STATE: rd_d = {7'h0, warn_s2_q && det_en}; // RULE16
            default: rd_d = `RESET_BYTE;
        endcase
    end

    // Read data register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) rdata <= `RESET_BYTE;
        else rdata <= rd_en ? rd_d : `RESET_BYTE;
    end

    // Fuse-loaded marker, set on the first edge after reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fuse_loaded_q <= 1'b0;
        end else begin
            fuse_loaded_q <= 1'b1;
        end
    end

    // Awake mode field
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            awake_mode_q <= 2'h0;
        end else begin
            awake_mode_q <= awake_mode_d; // RULE4
        end
    end

    // Sleep mode field
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sleep_mode_q <= 2'h0;
        end else begin
            sleep_mode_q <= sleep_mode_d; // RULE7
        end
    end

    // Sample rate bit
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sample_rate_sel_q <= 1'b0;
        end else begin
            sample_rate_sel_q <= sample_rate_sel_d; // RULE8
        end
    end

    // Threshold level field
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            threshold_q <= 3'h0;
        end else begin
            threshold_q <= threshold_d; // RULE11
        end
    end

    // Warning margin field
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            margin_q <= 2'h0;
        end else begin
            margin_q <= margin_d; // RULE12
        end
    end

    // Trigger type field
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trigger_q <= 2'h0;
        end else begin
            trigger_q <= trigger_d; // RULE13
        end
    end

    // Interrupt enable bit
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_en_q <= 1'b0;
        end else begin
            irq_en_q <= irq_en_d; // RULE14
        end
    end

    // Warning flag
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d; // RULE2
        end
    end

    // Unlock window counter
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            unlock_cnt_q <= 3'h0;
        end else begin
            unlock_cnt_q <= unlock_cnt_d; // RULE6
        end
    end

    // Warning comparator synchroniser
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            warn_s1_q <= 1'b0;
            warn_s2_q <= 1'b0;
        end else begin
            warn_s1_q <= warn_cmp; // RULE20
            warn_s2_q <= warn_s1_q;
        end
    end

    // Warning edge history
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            warn_prev_q <= 1'b0;
        end else begin
            warn_prev_q <= warn_prev_d; // RULE20
        end
    end

    // Brown-out comparator synchroniser
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bo_s1_q <= 1'b0;
            bo_s2_q <= 1'b0;
        end else begin
            bo_s1_q <= brownout_cmp;
            bo_s2_q <= bo_s1_q;
        end
    end

    // Sample tick generator
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            samp_cnt_q <= 32'h0;
            samp_tick_q <= 1'b0;
        end else begin
            samp_cnt_q <= samp_cnt_d;
            samp_tick_q <= samp_wrap;
        end
    end

    // Deep sleep tracking
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_deep; // RULE5
        end
    end

    // Wake stall counter
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wake_cnt_q <= 32'h0;
        end else begin
            wake_cnt_q <= wake_cnt_d;
        end
    end

    // Wake stall output
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wake_stall <= 1'b0;
        end else begin
            wake_stall <= wake_stall_d; // RULE9
        end
    end

    // Detector activity outputs
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            detector_on <= 1'b0;
            detector_sample <= 1'b0;
        end else begin
            detector_on <= det_en;
            detector_sample <= det_en && det_samp; // RULE17
        end
    end

    // Level selections to the analog side
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            brownout_threshold_sel <= 3'h0;
            early_warn_margin_sel <= 2'h0;
        end else begin
            brownout_threshold_sel <= threshold_q; // RULE11
            early_warn_margin_sel <= margin_q; // RULE12
        end
    end

    // Warning interrupt request, muted while debug halted
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            early_warn_irq <= 1'b0;
        end else begin
            early_warn_irq <= irq_en_q && flag_q && !debug_halted; // RULE3 RULE1
        end
    end

    // System reset request below the brown-out level
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            system_reset_req <= 1'b0;
        end else begin
            system_reset_req <= det_en && bo_s2_q; // RULE18
        end
    end
endmodule : brownout_monitor_control
`default_nettype wire

// ### verification/brownout_monitor_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module brownout_monitor_control_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic debug_halted,
    input wire logic detector_on,
    input wire logic [2:0] brownout_threshold_sel,
    input wire logic [1:0] early_warn_margin_sel,
    input wire logic early_warn_irq,
    input wire logic wake_stall
);
    // Write decodes used by the properties
    logic [1:0] wlow;
    logic drop_req;
    assign wlow = wdata[1:0];
    assign drop_req = wr_en && ((addr == 4'hA && wdata[0]) || (addr == 4'h9 && !wdata[0]));
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Register and interrupt relations
    a_debug_mute: assert property (debug_halted |=> !early_warn_irq)
        else $error("Interrupt raised while debug halted");
    a_irq_holds: assert property ($fell(early_warn_irq) |-> $past(debug_halted) || $past(drop_req, 2))
        else $error("Interrupt dropped without clear");
    a_level_fixed: assert property (wr_en && addr == 4'h1 |=> $stable(brownout_threshold_sel))
        else $error("Threshold level changed by write");
    a_level_read: assert property (rd_en && addr == 4'h1 |=> rdata == {5'h00, $past(brownout_threshold_sel)})
        else $error("Threshold readback wrong");
    a_margin_write: assert property (wr_en && addr == 4'h8 |=> ##1 early_warn_margin_sel == $past(wlow, 2))
        else $error("Margin not taken from write");
    a_irq_disable: assert property (wr_en && addr == 4'h9 && !wdata[0] |=> ##1 !early_warn_irq)
        else $error("Interrupt while disabled");
    a_state_off: assert property (rd_en && addr == 4'hB && !detector_on |=> rdata == 8'h00)
        else $error("State nonzero with detector off");
    a_stall_hold: assert property ($rose(wake_stall) |=> wake_stall [*8])
        else $error("Wake stall too short");
    // Main scenarios reached
    c_irq_cleared: cover property (early_warn_irq ##1 !early_warn_irq);
    c_flag_read: cover property (rd_en && addr == 4'hA ##1 rdata[0]);
    c_wake_stall: cover property ($rose(wake_stall));
endmodule : brownout_monitor_control_checker
bind brownout_monitor_control brownout_monitor_control_checker chk_u (.clk_sys, .reset, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .debug_halted, .detector_on, .brownout_threshold_sel, .early_warn_margin_sel,
    .early_warn_irq, .wake_stall);
`default_nettype wire

// ### verification/brownout_monitor_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module brownout_monitor_control_bench;
    logic clk_sys = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, unlock_key_written = 1'b0;
    logic instr_retired = 1'b0, sleep_deep = 1'b0, debug_halted = 1'b0, brownout_cmp = 1'b0, warn_cmp = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [1:0] fuse_sleep_mode = 2'h2, fuse_awake_mode = 2'h1, early_warn_margin_sel;
    logic fuse_sample_rate = 1'b1;
    logic [2:0] fuse_threshold = 3'h7, brownout_threshold_sel;
    logic detector_on, detector_sample, early_warn_irq, wake_stall, system_reset_req;
    int miscompares = 0;
    int num_checks = 0;
    brownout_monitor_control #(.FAST_CYC(8), .SLOW_CYC(16)) dut_u (.clk_sys, .reset, .addr, .wdata, .wr_en,
        .rd_en, .rdata, .fuse_sleep_mode, .fuse_awake_mode, .fuse_sample_rate, .fuse_threshold,
        .unlock_key_written, .instr_retired, .sleep_deep, .debug_halted, .brownout_cmp, .warn_cmp, .detector_on,
        .detector_sample, .brownout_threshold_sel, .early_warn_margin_sel, .early_warn_irq, .wake_stall,
        .system_reset_req);
    // Clock at 50 MHz
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd
    // Key pulse, then n retired instructions
    task automatic key(input int n);
        @(posedge clk_sys);
        unlock_key_written <= 1'b1;
        @(posedge clk_sys);
        unlock_key_written <= 1'b0;
        repeat (n) begin
            instr_retired <= 1'b1;
            @(posedge clk_sys);
        end
        instr_retired <= 1'b0;
    endtask : key
    task automatic lvl(input logic v);
        @(posedge clk_sys);
        warn_cmp <= v;
        repeat (6) @(posedge clk_sys);
    endtask : lvl
    // Hang guard
    initial begin
        #100us;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(4'h0, 8'h16);
        rd(4'h1, 8'h07);
        rd(4'h8, 8'h00);
        rd(4'h9, 8'h00);
        rd(4'hA, 8'h00);
        $display("reset values done");
        wr(4'h0, 8'h0D);
        wr(4'h1, 8'h00);
        rd(4'h0, 8'h06);
        rd(4'h1, 8'h07);
        key(3);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h04);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h04);
        key(5);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h04);
        $display("unlock done");
        wr(4'h8, 8'h02);
        rd(4'h8, 8'h02);
        wr(4'h9, 8'h05);
        lvl(1'b1);
        rd(4'hA, 8'h01);
        rd(4'hB, 8'h01);
        check({7'h00, early_warn_irq}, 8'h01);
        @(posedge clk_sys);
        debug_halted <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check({7'h00, early_warn_irq}, 8'h00);
        debug_halted <= 1'b0;
        wr(4'hA, 8'h01);
        rd(4'hA, 8'h00);
        check({7'h00, early_warn_irq}, 8'h00);
        wr(4'h9, 8'h03);
        lvl(1'b0);
        rd(4'hA, 8'h01);
        wr(4'hA, 8'h01);
        lvl(1'b1);
        rd(4'hA, 8'h00);
        wr(4'h9, 8'h00);
        lvl(1'b0);
        lvl(1'b1);
        rd(4'hA, 8'h01);
        check({7'h00, early_warn_irq}, 8'h00);
        wr(4'hA, 8'h00);
        rd(4'hA, 8'h01);
        wr(4'hA, 8'h01);
        $display("warning flag done");
        brownout_cmp <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({7'h00, system_reset_req}, 8'h01);
        brownout_cmp <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({7'h00, system_reset_req}, 8'h00);
        $display("brown-out reset done");
        sleep_deep <= 1'b1;
        lvl(1'b0);
        check({7'h00, detector_on}, 8'h00);
        lvl(1'b1);
        rd(4'hA, 8'h00);
        @(posedge clk_sys);
        sleep_deep <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({7'h00, detector_on}, 8'h01);
        rd(4'hB, 8'h01);
        $display("sleep done");
        key(1);
        wr(4'h0, 8'h12);
        rd(4'h0, 8'h16);
        @(posedge clk_sys);
        sleep_deep <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({7'h00, detector_sample}, 8'h01);
        warn_cmp <= 1'b0;
        repeat (40) @(posedge clk_sys);
        warn_cmp <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rd(4'hA, 8'h01);
        $display("sampled mode done");
        @(posedge clk_sys);
        sleep_deep <= 1'b0;
        fuse_awake_mode <= 2'h3;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        sleep_deep <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sleep_deep <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({7'h00, wake_stall}, 8'h01);
        repeat (20) @(posedge clk_sys);
        check({7'h00, wake_stall}, 8'h00);
        $display("wake stall done");
        summarize();
    end
endmodule : brownout_monitor_control_bench
`default_nettype wire
